// ===== rtl/two_wire_frame_output_port.sv
// two-wire frame output port: strap latch, frame builder, watchdog, apb status
// assumes the host serial clock arrives as a pin far slower than clk_in
//
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module two_wire_frame_output_port
	import two_wire_frame_pkg::*;
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic interface_select_pin_in,
	input wire logic oversample_strap_lo_in,
	input wire logic oversample_strap_hi_in,
	input wire logic boost_strap_in,
	input wire logic ch0_gain_strap_lo_in,
	input wire logic ch0_gain_strap_hi_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	output logic sdo_out,
	output logic [1:0] modulator_bitstream_outs_out,
	output logic [1:0] modulator_bitstream_oe_out,
	output logic two_wire_mode_out,
	output logic [9:0] oversampling_ratio_out,
	output logic [5:0] ch0_gain_out,
	output logic boost_full_out,
	output logic converter_reset_out
);

	// ************************************************
	// pin synchronisers
	// ************************************************
	// bit 0 clock, 1 select, 2..6 straps osr_lo, osr_hi, boost, gain_lo, gain_hi
	logic [6:0] sync1_reg, sync2_reg, sync3_reg, level_reg, level_next;

	always_comb
	begin
		level_next = level_reg;
		for (int i = 0; i < 7; i++)
		begin
			if (sync2_reg[i] == sync3_reg[i])
				level_next[i] = sync3_reg[i];
		end
	end

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			sync1_reg <= 7'h00;
			sync2_reg <= 7'h00;
			sync3_reg <= 7'h00;
			level_reg <= 7'h00;
		end
		else
		begin
			sync1_reg <= {ch0_gain_strap_hi_in, ch0_gain_strap_lo_in, boost_strap_in,
				oversample_strap_hi_in, oversample_strap_lo_in, interface_select_pin_in, sck_in};
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			level_reg <= level_next;
		end
	end

	// ************************************************
	// main state
	// ************************************************
	state_type state_reg, state_next;
	logic sck_prev_reg, sck_prev_next;
	logic sel_prev_reg, sel_prev_next;
	logic [1:0] start_cnt_reg, start_cnt_next;
	logic latched_reg, latched_next;
	logic mode_reg, mode_next;
	logic [4:0] strap_reg, strap_next;
	logic [7:0] wd_cnt_reg, wd_cnt_next;
	logic wd_reset_reg, wd_reset_next;
	logic [13:0] conv_cnt_reg, conv_cnt_next;
	logic settled_reg, settled_next;
	logic pending_reg, pending_next;
	logic [1:0] frame_cnt_reg, frame_cnt_next;
	logic [6:0] bit_cnt_reg, bit_cnt_next;
	logic [103:0] frame_reg, frame_next;
	logic [15:0] crc_reg, crc_next;
	logic [71:0] shadow_reg, shadow_next;
	logic sdo_reg, sdo_next;
	logic [23:0] ch_reg [3], ch_next [3];
	logic [31:0] prdata_reg, prdata_next;
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;

	// comb temporaries
	logic sck_rise, sck_fall, sel_rise, long_frame, emit;
	logic [9:0] oversampling_ratio;
	logic [13:0] conv_limit;
	logic [6:0] payload_len, last_bit;
	logic [103:0] cur_frame;
	logic [15:0] cur_crc, sync_word;
	logic [31:0] status_word;
	logic [1:0] widx;

	function automatic logic [103:0] build_frame(input logic lng, input logic [15:0] sync,
		input logic [71:0] data);
		if (lng)
			build_frame = {sync, data, 16'h0000};
		else
			build_frame = {sync, data[71:56], data[47:32], data[23:8], 40'h0000000000};
	endfunction

	always_comb
	begin
		state_next = state_reg;
		sck_prev_next = level_reg[0];
		sel_prev_next = level_reg[1];
		start_cnt_next = start_cnt_reg;
		latched_next = latched_reg;
		mode_next = mode_reg;
		strap_next = strap_reg;
		wd_cnt_next = wd_cnt_reg;
		wd_reset_next = 1'b0;
		conv_cnt_next = conv_cnt_reg;
		settled_next = settled_reg;
		pending_next = pending_reg;
		frame_cnt_next = frame_cnt_reg;
		bit_cnt_next = bit_cnt_reg;
		frame_next = frame_reg;
		crc_next = crc_reg;
		shadow_next = shadow_reg;
		sdo_next = sdo_reg;
		ch_next = ch_reg;
		prdata_next = prdata_reg;
		pready_next = 1'b0;
		pslverr_next = 1'b0;
		cur_frame = frame_reg;
		cur_crc = crc_reg;
		emit = 1'b0;
		widx = 2'h0;

		sck_rise = level_reg[0] & ~sck_prev_reg;
		sck_fall = ~level_reg[0] & sck_prev_reg;
		sel_rise = level_reg[1] & ~sel_prev_reg;
		oversampling_ratio = osr_value(strap_reg[1:0]);
		long_frame = (strap_reg[1:0] != 2'h0);
		payload_len = long_frame ? PAYLOAD_LONG : PAYLOAD_SHORT;
		last_bit = 7'(payload_len + CRC_BITS - 7'h01);
		// first result: start delay of 2 x osr, then the filter settles
		conv_limit = settled_reg ? 14'({oversampling_ratio, 2'b00} - 12'h001)
			: 14'({oversampling_ratio, 1'b0} + 14'(SETTLE_PERIODS) * {oversampling_ratio, 2'b00} - 14'h0001);
		sync_word = {SYNC_BYTE, 1'b0, strap_reg[1], strap_reg[0], strap_reg[2],
			strap_reg[4], strap_reg[3], frame_cnt_reg[1], frame_cnt_reg[0]};
		status_word = 32'h00000000;
		status_word[ST_MODE] = mode_reg;
		status_word[ST_OSR_LO +: 2] = strap_reg[1:0];
		status_word[ST_BOOST] = strap_reg[2];
		status_word[ST_GAIN_LO +: 2] = strap_reg[4:3];
		status_word[ST_CNT_LO +: 2] = frame_cnt_reg;
		status_word[ST_SENDING] = (state_reg == ST_SEND);
		status_word[ST_SETTLED] = settled_reg;

		// select pin sampled once the synchronisers hold the released value
		if (!latched_reg)
		begin
			start_cnt_next = 2'(start_cnt_reg + 2'h1);
			if (start_cnt_reg == START_WAIT)
			begin
				latched_next = 1'b1;
				mode_next = level_next[1];
				if (level_next[1])
					strap_next = level_next[6:2];
			end
		end
		else if (sel_rise)
			strap_next = level_reg[6:2];

		if (mode_reg)
		begin
			// long high clock trips a full reset; low levels never do
			if (!level_reg[0])
				wd_cnt_next = 8'h00;
			else if (wd_cnt_reg == 8'(WD_CYCLES - 1))
				wd_reset_next = 1'b1;
			else
				wd_cnt_next = 8'(wd_cnt_reg + 8'h01);
			// conversion timing counts host clock rising edges only
			if (sck_rise)
			begin
				if (conv_cnt_reg == conv_limit)
				begin
					conv_cnt_next = 14'h0000;
					settled_next = 1'b1;
					pending_next = 1'b1;
				end
				else
					conv_cnt_next = 14'(conv_cnt_reg + 14'h0001);
			end
			// output bits change on the host clock falling edge
			if (sck_fall)
			begin
				if (state_reg == ST_IDLE)
				begin
					sdo_next = 1'b0;
					if (pending_reg)
					begin
						state_next = ST_SEND;
						pending_next = sck_rise;
						shadow_next = {ch_reg[0], ch_reg[1], ch_reg[2]};
						frame_cnt_next = 2'h0;
						bit_cnt_next = 7'h00;
						emit = 1'b1;
					end
				end
				else
					emit = 1'b1;
			end
			if (emit)
			begin
				if (bit_cnt_next == 7'h00)
				begin
					cur_frame = build_frame(long_frame, {sync_word[15:2], frame_cnt_next}, shadow_next);
					cur_crc = CRC_INIT;
				end
				if (bit_cnt_next < payload_len)
				begin
					sdo_next = cur_frame[103];
					crc_next = crc_step(cur_crc, cur_frame[103]);
					frame_next = {cur_frame[102:0], 1'b0};
				end
				else
				begin
					sdo_next = cur_crc[15];
					crc_next = {cur_crc[14:0], 1'b0};
				end
				bit_cnt_next = 7'(bit_cnt_next + 7'h01);
				if (bit_cnt_next == 7'(last_bit + 7'h01))
				begin
					bit_cnt_next = 7'h00;
					if (frame_cnt_next != LAST_FRAME)
						frame_cnt_next = 2'(frame_cnt_next + 2'h1);
					else if (pending_next)
					begin
						// fresh data already waiting: no idle gap
						frame_cnt_next = 2'h0;
						pending_next = sck_rise;
						shadow_next = {ch_reg[0], ch_reg[1], ch_reg[2]};
					end
					else
						state_next = ST_IDLE;
				end
			end
		end
		else
			sdo_next = 1'b0;

		// apb slave: one wait state, error on unmapped addresses
		if (psel_in && penable_in && !pready_reg)
		begin
			pready_next = 1'b1;
			unique case (paddr_in)
				ADDR_CH0: prdata_next = {8'h00, ch_reg[0]};
				ADDR_CH1: prdata_next = {8'h00, ch_reg[1]};
				ADDR_CH2: prdata_next = {8'h00, ch_reg[2]};
				ADDR_STATUS: prdata_next = status_word;
				default:
				begin
					prdata_next = 32'h00000000;
					pslverr_next = 1'b1;
				end
			endcase
		end
		if (psel_in && penable_in && pready_reg && pwrite_in && !pslverr_reg && paddr_in != ADDR_STATUS)
		begin
			widx = paddr_in[3:2];
			ch_next[widx] = pwdata_in[23:0];
		end
	end

	// a watchdog trip clears everything below as a reset would
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			state_reg <= ST_IDLE;
			start_cnt_reg <= 2'h0;
			latched_reg <= 1'b0;
			mode_reg <= 1'b0;
			strap_reg <= 5'h00;
			wd_cnt_reg <= 8'h00;
			wd_reset_reg <= 1'b0;
			conv_cnt_reg <= 14'h0000;
			settled_reg <= 1'b0;
			pending_reg <= 1'b0;
			frame_cnt_reg <= 2'h0;
			bit_cnt_reg <= 7'h00;
			frame_reg <= 104'h0;
			crc_reg <= CRC_INIT;
			shadow_reg <= 72'h0;
			sdo_reg <= 1'b0;
			ch_reg <= '{24'h000000, 24'h000000, 24'h000000};
		end
		else if (wd_reset_reg)
		begin
			state_reg <= ST_IDLE;
			start_cnt_reg <= 2'h0;
			latched_reg <= 1'b0;
			mode_reg <= 1'b0;
			strap_reg <= 5'h00;
			wd_cnt_reg <= 8'h00;
			wd_reset_reg <= 1'b0;
			conv_cnt_reg <= 14'h0000;
			settled_reg <= 1'b0;
			pending_reg <= 1'b0;
			frame_cnt_reg <= 2'h0;
			bit_cnt_reg <= 7'h00;
			frame_reg <= 104'h0;
			crc_reg <= CRC_INIT;
			shadow_reg <= 72'h0;
			sdo_reg <= 1'b0;
			ch_reg <= '{24'h000000, 24'h000000, 24'h000000};
		end
		else
		begin
			state_reg <= state_next;
			start_cnt_reg <= start_cnt_next;
			latched_reg <= latched_next;
			mode_reg <= mode_next;
			strap_reg <= strap_next;
			wd_cnt_reg <= wd_cnt_next;
			wd_reset_reg <= wd_reset_next;
			conv_cnt_reg <= conv_cnt_next;
			settled_reg <= settled_next;
			pending_reg <= pending_next;
			frame_cnt_reg <= frame_cnt_next;
			bit_cnt_reg <= bit_cnt_next;
			frame_reg <= frame_next;
			crc_reg <= crc_next;
			shadow_reg <= shadow_next;
			sdo_reg <= sdo_next;
			ch_reg <= ch_next;
		end
	end

	// ************************************************
	// outputs
	// ************************************************
	logic [9:0] osr_out_reg;
	logic [5:0] gain_out_reg;
	logic boost_out_reg, mode_out_reg;
	logic [1:0] mdat_oe_reg;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			osr_out_reg <= 10'h040;
			gain_out_reg <= 6'h01;
			boost_out_reg <= 1'b0;
			mode_out_reg <= 1'b0;
			mdat_oe_reg <= 2'h0;
			sck_prev_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
			prdata_reg <= 32'h00000000;
			pready_reg <= 1'b0;
			pslverr_reg <= 1'b0;
		end
		else
		begin
			osr_out_reg <= osr_value(strap_reg[1:0]);
			gain_out_reg <= gain_value(strap_reg[4:3]);
			boost_out_reg <= strap_reg[2];
			mode_out_reg <= mode_reg;
			mdat_oe_reg <= 2'h0;
			sck_prev_reg <= sck_prev_next;
			sel_prev_reg <= sel_prev_next;
			prdata_reg <= prdata_next;
			pready_reg <= pready_next;
			pslverr_reg <= pslverr_next;
		end
	end

	assign prdata_out = prdata_reg;
	assign pready_out = pready_reg;
	assign pslverr_out = pslverr_reg;
	assign sdo_out = sdo_reg;
	assign modulator_bitstream_outs_out = mdat_oe_reg;
	assign modulator_bitstream_oe_out = mdat_oe_reg;
	assign two_wire_mode_out = mode_out_reg;
	assign oversampling_ratio_out = osr_out_reg;
	assign ch0_gain_out = gain_out_reg;
	assign boost_full_out = boost_out_reg;
	assign converter_reset_out = wd_reset_reg;

endmodule
`default_nettype wire

// ===== rtl/two_wire_frame_pkg.sv
// constants, types and helpers for the two-wire frame output port
// assumes a 50 MHz system clock that oversamples the host serial clock
// Function
// - serial data line is always driven and stays low between frames
// - frames go out on their own at each new conversion result
// - host serial clock is the master clock for conversion and output timing
// - five former control pins act as oversampling, boost and gain straps
// - both modulator bitstream outputs stay disabled in this mode
// - interface select pin is sampled only when leaving a reset
// - all settings keep defaults except channel 0 gain, ratio and boost
// - the five straps are captured on the select pin rising edge
// - ratio straps high,low: 00=64, 01=128, 10=256, 11=512
// - boost strap low gives half bias current, high gives full
// - gain straps high,low: 00=1, 01=8, 10=16, 11=32
// - lowest ratio: sync word, three 16-bit results, 16-bit checksum
// - higher ratios: 104-bit frame, sync, three 24-bit results, checksum
// - sync word holds straps, frame count and constant byte 0xA5
// - four frames per data set counted 00 to 11, then line low
// - lowest ratio: next frame set follows the previous one with no idle
// - no frame before the first result after filter settling
// - conversions start after twice the ratio in master clock periods
// - clock held high past the watchdog limit resets the whole block
// - checksum uses polynomial x16+x15+x2+1, 0x8005
package two_wire_frame_pkg;

	// ************************************************
	// timing
	// ************************************************
	localparam int CLK_PERIOD_NS = 20;
	localparam int WATCHDOG_LIMIT_NS = 3600;
	localparam int WD_CYCLES = (WATCHDOG_LIMIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_PERIODS = 3;
	localparam logic [1:0] START_WAIT = 2'h3;

	// ************************************************
	// register map
	// ************************************************
	localparam logic [11:0] ADDR_CH0 = 12'h000;
	localparam logic [11:0] ADDR_CH1 = 12'h004;
	localparam logic [11:0] ADDR_CH2 = 12'h008;
	localparam logic [11:0] ADDR_STATUS = 12'h00C;
	localparam int ST_MODE = 0;
	localparam int ST_OSR_LO = 1;
	localparam int ST_BOOST = 3;
	localparam int ST_GAIN_LO = 4;
	localparam int ST_CNT_LO = 6;
	localparam int ST_SENDING = 8;
	localparam int ST_SETTLED = 9;

	// ************************************************
	// frame layout
	// ************************************************
	localparam logic [7:0] SYNC_BYTE = 8'hA5;
	localparam logic [15:0] CRC_POLY = 16'h8005;
	localparam logic [15:0] CRC_INIT = 16'h0000;
	localparam logic [6:0] PAYLOAD_LONG = 7'h58;
	localparam logic [6:0] PAYLOAD_SHORT = 7'h40;
	localparam logic [6:0] CRC_BITS = 7'h10;
	localparam logic [1:0] LAST_FRAME = 2'h3;

	typedef enum logic {ST_IDLE = 1'b0, ST_SEND = 1'b1} state_type;

	// oversampling ratio 64 shifted left by the strap code
	function automatic logic [9:0] osr_value(input logic [1:0] code);
		osr_value = 10'h040 << code;
	endfunction

	function automatic logic [5:0] gain_value(input logic [1:0] code);
		unique case (code)
			2'h0: gain_value = 6'h01;
			2'h1: gain_value = 6'h08;
			2'h2: gain_value = 6'h10;
			2'h3: gain_value = 6'h20;
		endcase
	endfunction

	function automatic logic [15:0] crc_step(input logic [15:0] crc, input logic din);
		logic fb;
		fb = crc[15] ^ din;
		crc_step = {crc[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
	endfunction

endpackage

// ===== verif/two_wire_frame_checker.sv
// concurrent checks on the pins of the two-wire frame output port
// assumes it is bound into the port and sees only its top-level signals
`timescale 1ns/1ps
`default_nettype none
module two_wire_frame_checker
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic sck_in,
	input wire logic oversample_strap_lo_in,
	input wire logic oversample_strap_hi_in,
	input wire logic boost_strap_in,
	input wire logic ch0_gain_strap_lo_in,
	input wire logic ch0_gain_strap_hi_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pready_out,
	input wire logic sdo_out,
	input wire logic [1:0] modulator_bitstream_outs_out,
	input wire logic [1:0] modulator_bitstream_oe_out,
	input wire logic two_wire_mode_out,
	input wire logic [9:0] oversampling_ratio_out,
	input wire logic [5:0] ch0_gain_out,
	input wire logic boost_full_out,
	input wire logic converter_reset_out
);
	// ************************************************
	// helper counters
	// ************************************************
	logic [7:0] since_rst_reg;
	logic [8:0] high_cnt_reg;
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			since_rst_reg <= 8'h00;
			high_cnt_reg <= 9'h000;
		end
		else
		begin
			since_rst_reg <= converter_reset_out ? 8'h00 : since_rst_reg + {7'h00, since_rst_reg != 8'hFF};
			high_cnt_reg <= !sck_in ? 9'h000 : high_cnt_reg + {8'h00, high_cnt_reg != 9'h1FF};
		end
	end
	default clocking main_cb @(posedge clk_in);
	endclocking
	default disable iff (rst_in);
	function automatic logic [5:0] gain_of(input logic [1:0] code);
		return (code == 2'h0) ? 6'h01 : (6'h04 << code);
	endfunction
	sequence apb_setup;
		psel_in && !penable_in;
	endsequence
	// raw pin high for 178 cycles; the synchroniser adds a few more before the trip
	sequence sck_stuck;
		two_wire_mode_out && high_cnt_reg == 9'h0B2;
	endsequence
	// ************************************************
	// assertions
	// ************************************************
	a_sdo_idle_low: assert property (!two_wire_mode_out |-> !sdo_out)
		else $error("data line high outside the two-wire mode");
	a_modulator_off: assert property (modulator_bitstream_oe_out == 2'h0 && modulator_bitstream_outs_out == 2'h0)
		else $error("modulator outputs enabled");
	a_mode_hold: assert property ($changed(two_wire_mode_out) |-> since_rst_reg < 8'h08 || converter_reset_out)
		else $error("mode changed away from a reset exit");
	a_straps_hold: assert property (($changed(oversampling_ratio_out) || $changed(ch0_gain_out)
		|| $changed(boost_full_out)) |-> since_rst_reg < 8'h08 || converter_reset_out)
		else $error("strap setting changed away from a reset exit");
	a_ratio_map: assert property ($rose(two_wire_mode_out) |-> ##[0:2]
		oversampling_ratio_out == (10'h040 << {oversample_strap_hi_in, oversample_strap_lo_in}))
		else $error("ratio does not match the straps");
	a_gain_map: assert property ($rose(two_wire_mode_out) |-> ##[0:2]
		ch0_gain_out == gain_of({ch0_gain_strap_hi_in, ch0_gain_strap_lo_in}))
		else $error("gain does not match the straps");
	a_boost_map: assert property ($rose(two_wire_mode_out) |-> ##[0:2] boost_full_out == boost_strap_in)
		else $error("boost does not match its strap");
	a_wd_trip: assert property (sck_stuck |-> ##[1:20] converter_reset_out)
		else $error("stuck clock did not reset the port");
	a_wd_cause: assert property (converter_reset_out |-> high_cnt_reg > 9'h0AF)
		else $error("reset without a stuck-high clock");
	a_apb_answer: assert property (apb_setup ##1 (psel_in && penable_in) |-> !pready_out ##1 pready_out)
		else $error("bus answer not in the second access cycle");
	a_ready_pulse: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
endmodule
bind two_wire_frame_output_port two_wire_frame_checker frame_checker (.*);
`default_nettype wire

// ===== verif/two_wire_host_model.sv
// host-side model: serial clock that stall_in holds high, and a catcher on the data line
// assumes the bench reads and clears its queue and counters by name
`timescale 1ns/1ps
`default_nettype none
module two_wire_host_model
(
	input wire logic stall_in,
	input wire logic sdo_in,
	output logic sck_out
);
	int rises;
	int start_rise;
	bit started;
	bit rx_q[$];
	initial
	begin
		sck_out = 1'b0;
		// offset keeps the link clock out of phase with the system clock
		#7;
		forever
		begin
			#80 sck_out = 1'b1;
			rises++;
			#80;
			wait (!stall_in);
			sck_out = 1'b0;
		end
	end
	// sample on the fall, before the port moves the line again
	always @(negedge sck_out)
	begin
		if (started || sdo_in)
		begin
			if (!started)
				start_rise = rises;
			started = 1'b1;
			rx_q.push_back(sdo_in);
		end
	end
endmodule
`default_nettype wire

// ===== verif/two_wire_frame_output_port_bench.sv
// self-checking bench: straps, bus access, frame sets at two ratios, watchdog
// assumes the host model on the link and the checker bound into the port
`timescale 1ns/1ps
`default_nettype none
module two_wire_frame_output_port_bench import two_wire_frame_pkg::*;;
	logic clk_in = 1'b0, rst_in = 1'b1, mode = 1'b0, stall = 1'b0, boost = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [1:0] s_osr = 2'h0, s_gain = 2'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h00000000, lfsr = 32'h00013A3A;
	logic [23:0] ch [3];
	logic sck, sdo_out, pready_out, pslverr_out, two_wire_mode_out, boost_full_out, converter_reset_out;
	logic [31:0] prdata_out;
	logic [9:0] ratio;
	logic [5:0] gain;
	int failures = 0, n_tests = 0, cycles = 0;
	bit ex[$];
	two_wire_frame_output_port dut (.clk_in(clk_in), .rst_in(rst_in), .sck_in(sck),
		.interface_select_pin_in(mode), .oversample_strap_lo_in(s_osr[0]), .oversample_strap_hi_in(s_osr[1]),
		.boost_strap_in(boost), .ch0_gain_strap_lo_in(s_gain[0]), .ch0_gain_strap_hi_in(s_gain[1]),
		.psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .sdo_out(sdo_out),
		.modulator_bitstream_outs_out(), .modulator_bitstream_oe_out(), .two_wire_mode_out(two_wire_mode_out),
		.oversampling_ratio_out(ratio), .ch0_gain_out(gain), .boost_full_out(boost_full_out),
		.converter_reset_out(converter_reset_out));
	two_wire_host_model link (.stall_in(stall), .sdo_in(sdo_out), .sck_out(sck));
	always #10 clk_in = ~clk_in;
	// ************************************************
	// shared tasks
	// ************************************************
	task automatic finish_test();
		$display("failures %0d n_tests %0d", failures, n_tests);
		if (failures == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge clk_in)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			failures++;
			finish_test();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
		output logic e);
		int n;
		n = 0;
		@(posedge clk_in);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_in);
		penable <= 1'b1;
		do
		begin
			@(posedge clk_in);
			n++;
		end
		while (pready_out !== 1'b1);
		check(n, 2);
		r = prdata_out;
		e = pslverr_out;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic do_reset(input logic [1:0] o, input logic b, input logic [1:0] g, input logic m);
		@(posedge clk_in);
		s_osr <= o;
		boost <= b;
		s_gain <= g;
		mode <= m;
		rst_in <= 1'b1;
		repeat (5) @(posedge clk_in);
		rst_in <= 1'b0;
		link.rises = 0;
		link.started = 0;
		link.rx_q.delete();
		repeat (8) @(posedge clk_in);
	endtask
	function automatic logic [31:0] lfsr_next(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task automatic load_channels();
		logic [31:0] r;
		logic e;
		for (int c = 0; c < 3; c++)
		begin
			lfsr = lfsr_next(lfsr);
			ch[c] = lfsr[23:0];
			apb(1'b1, ADDR_CH0 + 12'(4 * c), {8'h00, ch[c]}, r, e);
			apb(1'b0, ADDR_CH0 + 12'(4 * c), 32'h00000000, r, e);
			check(r, {8'h00, ch[c]});
		end
	endtask
	task automatic push_bit(input bit b, inout logic [15:0] crc);
		ex.push_back(b);
		crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b) ? 16'h8005 : 16'h0000);
	endtask
	// four frames of the expected set; the low ratio keeps only the upper 16 data bits
	task automatic build_set();
		logic [15:0] crc;
		logic [15:0] sync;
		int dw;
		dw = (s_osr == 2'h0) ? 16 : 24;
		for (int f = 0; f < 4; f++)
		begin
			crc = 16'h0000;
			sync = {8'hA5, 1'b0, s_osr, boost, s_gain, 2'(f)};
			for (int i = 15; i >= 0; i--)
				push_bit(sync[i], crc);
			for (int c = 0; c < 3; c++)
				for (int i = 23; i >= 24 - dw; i--)
					push_bit(ch[c][i], crc);
			for (int i = 15; i >= 0; i--)
				ex.push_back(crc[i]);
		end
	endtask
	task automatic get_set(input int len, output int gap);
		gap = 0;
		build_set();
		forever
		begin
			while (link.rx_q.size() == 0) @(posedge clk_in);
			if (link.rx_q[0])
				break;
			void'(link.rx_q.pop_front());
			gap++;
		end
		for (int i = 0; i < 4 * len; i++)
		begin
			while (link.rx_q.size() == 0) @(posedge clk_in);
			check(32'(link.rx_q.pop_front()), 32'(ex.pop_front()));
		end
	endtask
	// ************************************************
	// main sequence
	// ************************************************
	initial
	begin
		int gap;
		int n;
		logic [31:0] r;
		logic e;
		repeat (2) @(posedge clk_in);
		rst_in <= 1'b0;
		for (int i = 3; i >= 0; i--)
		begin
			do_reset(2'(i), i[0], 2'(3 - i), 1'b1);
			check(ratio, 32'h40 << i);
			check(gain, (i == 3) ? 1 : (4 << (3 - i)));
			check(boost_full_out, i[0]);
			check(two_wire_mode_out, 1);
		end
		do_reset(2'h1, 1'b1, 2'h2, 1'b1);
		load_channels();
		apb(1'b0, 12'h010, 32'h00000000, r, e);
		check({r, e}, 1);
		apb(1'b1, ADDR_STATUS, 32'hFFFFFFFF, r, e);
		check(e, 0);
		apb(1'b0, ADDR_STATUS, 32'h00000000, r, e);
		check(r[5:0], {s_gain, boost, s_osr, 1'b1});
		get_set(104, gap);
		check(link.start_rise >= 14 * 128 - 2 && link.start_rise <= 14 * 128 + 4, 1);
		get_set(104, gap);
		check(gap, 4 * 128 - 4 * 104);
		mode <= 1'b0;
		repeat (4) @(posedge clk_in);
		stall <= 1'b1;
		n = 0;
		while (converter_reset_out !== 1'b1 && n < 400)
		begin
			@(posedge clk_in);
			n++;
		end
		check(n > 170 && n < 400, 1);
		stall <= 1'b0;
		repeat (10) @(posedge clk_in);
		check(two_wire_mode_out, 0);
		check({ratio, gain}, {10'h040, 6'h01});
		apb(1'b0, ADDR_CH0, 32'h00000000, r, e);
		check(r, 0);
		link.started = 0;
		link.rx_q.delete();
		repeat (2000) @(posedge clk_in);
		check(link.rx_q.size(), 0);
		do_reset(2'h0, 1'b0, 2'h0, 1'b1);
		load_channels();
		get_set(80, gap);
		get_set(80, gap);
		check(gap, 0);
		finish_test();
	end
endmodule
`default_nettype wire
